/* File: core/level_sync.sv */
// Two-stage synchroniser for a group of asynchronous levels
module level_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // Stages
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : level_sync

/* File: core/watchdog_pkg.sv */
// Constants for the watchdog timer: register map, fields, reset values and timing
package watchdog_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_RELOAD_VALUE = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_RESTART_STROBE = 8'h08;
    localparam logic [7:0] OFS_CURRENT_COUNT = 8'h0C;
    localparam logic [7:0] OFS_EXPIRY_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h14;

    // ==========================================================
    // Control field positions
    localparam int CTL_RUN_ENABLE = 0;
    localparam int CTL_TEST = 1;
    localparam int CTL_HIB_STALL = 2;
    localparam int CTL_WEEK_STALL = 3;
    localparam int CTL_DEBUG_STALL = 4;
    localparam int CTL_IRQ_SELECT = 9;

    // Status and enable field positions
    localparam int STS_EXPIRY_PENDING = 0;
    localparam int IEN_EXPIRY_ENABLE = 0;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET = 16'hFFFF;
    localparam logic [9:0] CONTROL_RESET = 10'h000;

    // ==========================================================
    // Timing: slow clock periods per count
    localparam int SLOW_PERIODS_PER_COUNT = 33;
    localparam logic [5:0] PRESCALE_LAST = 6'(SLOW_PERIODS_PER_COUNT - 1);

endpackage : watchdog_pkg

/* File: core/watchdog_timer.sv */
// Watchdog timer: host registers, slow-clock prescaler, down-counter, expiry handling
//
// Notes on behaviour
// - Counting advances only on slow clock edges.
// - System reset restores all block state except the preserved record.
// - Preserved record uses separate reset input.
// - Expiry raises interrupt (held until pending cleared) or pulses subsystem reset.
// - Expiry indication held until system reset.
// - Load reload first, then enable run.
// - Run enable cleared freezes counter.
// - Underflow emits expiry; status flag only in interrupt mode.
// - Reload on load write, restart, expiry.
// - Decrement once per 33 slow periods.
// - Enabled stall holds count, then resumes.
// - Six registers, offsets 00h to 14h.
// - Reload field 16 bits, write reloads.
// - Interrupt expiry clears select bit 9.
// - Bit 4 stalls on debug activity.
// - Bit 3 stalls on week timer.
// - Bit 2 stalls on hibernation timers.
// - Bit 0 run enable, bit 1 zero.
// - Restart strobe reads zero, acts when enabled.
// - Count register reads current counter value.
// - Status bit 0 pending, write-one clears.
// - Register accesses finish without slow clock.
module watchdog_timer (
    // Clock and resets
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic reset_except_expiry_n,
    // Slow clock and stall sources
    input wire logic slow_clk_32k,
    input wire logic debug_active,
    input wire logic week_timer_active,
    input wire logic hib_timer0_active,
    input wire logic hib_timer1_active,
    // Host register port
    input wire logic [7:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    // Expiry outputs
    output logic expiry_event,
    output logic expiry_interrupt,
    output logic subsystem_reset,
    output logic expiry_latched,
    output logic expiry_record
);

    // ==========================================================
    // Address decode
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

    // ==========================================================
    // Synchronisers
    logic [4:0] sync_lvl;

    level_sync #(
        .WIDTH(5)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .async_in({hib_timer1_active, hib_timer0_active, week_timer_active,
                   debug_active, slow_clk_32k}),
        .sync_out(sync_lvl)
    );

    // ==========================================================
    // State
    logic [15:0] reload_value_ff;
    logic [15:0] nxt_reload_value;
    logic [9:0] control_ff;
    logic [9:0] nxt_control;
    logic [15:0] current_count_ff;
    logic [15:0] nxt_current_count;
    logic [5:0] prescale_ff;
    logic [5:0] nxt_prescale;
    logic slow_prev_ff;
    logic nxt_slow_prev;
    logic expiry_pending_ff;
    logic nxt_expiry_pending;
    logic int_enable_ff;
    logic nxt_int_enable;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic event_ff;
    logic nxt_event;
    logic irq_ff;
    logic nxt_irq;
    logic sub_reset_ff;
    logic nxt_sub_reset;
    logic latched_ff;
    logic nxt_latched;
    logic record_ff;
    logic nxt_record;

    // ==========================================================
    // Event terms
    logic slow_rise;
    logic stall_active;
    logic running;
    logic load_wr;
    logic ctl_wr;
    logic kick_wr;
    logic kick_live;
    logic status_wr;
    logic ien_wr;
    logic tick_due;
    logic expire;

    always_comb begin
        slow_rise = sync_lvl[0] & ~slow_prev_ff;
        stall_active = (control_ff[watchdog_pkg::CTL_DEBUG_STALL] & sync_lvl[1])
            | (control_ff[watchdog_pkg::CTL_WEEK_STALL] & sync_lvl[2])
            | (control_ff[watchdog_pkg::CTL_HIB_STALL] & (sync_lvl[3] | sync_lvl[4]));
        running = control_ff[watchdog_pkg::CTL_RUN_ENABLE] & ~stall_active;
        load_wr = host_wr & reg_hit(host_addr, watchdog_pkg::OFS_RELOAD_VALUE);
        ctl_wr = host_wr & reg_hit(host_addr, watchdog_pkg::OFS_CONTROL);
        kick_wr = host_wr & reg_hit(host_addr, watchdog_pkg::OFS_RESTART_STROBE);
        status_wr = host_wr & reg_hit(host_addr, watchdog_pkg::OFS_EXPIRY_STATUS);
        ien_wr = host_wr & reg_hit(host_addr, watchdog_pkg::OFS_INT_ENABLE);
        kick_live = kick_wr & control_ff[watchdog_pkg::CTL_RUN_ENABLE];
        tick_due = running & slow_rise & (prescale_ff == watchdog_pkg::PRESCALE_LAST);
        expire = tick_due & (current_count_ff == 16'h0000) & ~load_wr & ~kick_live;
    end

    // ==========================================================
    // Counter and prescaler
    always_comb begin
        nxt_slow_prev = sync_lvl[0];
        nxt_reload_value = reload_value_ff;
        nxt_current_count = current_count_ff;
        nxt_prescale = prescale_ff;
        if (load_wr) begin
            nxt_reload_value = host_wdata[15:0];
            nxt_current_count = host_wdata[15:0];
            nxt_prescale = 6'h00;
        end else if (kick_live || expire) begin
            nxt_current_count = reload_value_ff;
            nxt_prescale = 6'h00;
        end else if (running && slow_rise) begin
            if (prescale_ff == watchdog_pkg::PRESCALE_LAST) begin
                nxt_prescale = 6'h00;
                nxt_current_count = current_count_ff - 16'h0001;
            end else begin
                nxt_prescale = prescale_ff + 6'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            slow_prev_ff <= 1'b0;
            reload_value_ff <= watchdog_pkg::RELOAD_RESET;
            current_count_ff <= watchdog_pkg::COUNT_RESET;
            prescale_ff <= 6'h00;
        end else begin
            slow_prev_ff <= nxt_slow_prev;
            reload_value_ff <= nxt_reload_value;
            current_count_ff <= nxt_current_count;
            prescale_ff <= nxt_prescale;
        end
    end

    // ==========================================================
    // Control, status and enable registers
    always_comb begin
        nxt_control = control_ff;
        nxt_int_enable = int_enable_ff;
        if (ctl_wr) begin
            nxt_control = host_wdata[9:0] & 10'h21D;
        end
        if (expire && control_ff[watchdog_pkg::CTL_IRQ_SELECT]) begin
            nxt_control[watchdog_pkg::CTL_IRQ_SELECT] = 1'b0;
        end
        if (ien_wr) begin
            nxt_int_enable = host_wdata[watchdog_pkg::IEN_EXPIRY_ENABLE];
        end
        nxt_expiry_pending = (expiry_pending_ff
            & ~(status_wr & host_wdata[watchdog_pkg::STS_EXPIRY_PENDING]))
            | (expire & control_ff[watchdog_pkg::CTL_IRQ_SELECT]);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            control_ff <= watchdog_pkg::CONTROL_RESET;
            int_enable_ff <= 1'b0;
            expiry_pending_ff <= 1'b0;
        end else begin
            control_ff <= nxt_control;
            int_enable_ff <= nxt_int_enable;
            expiry_pending_ff <= nxt_expiry_pending;
        end
    end

    // ==========================================================
    // Read data
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (host_rd) begin
            case (host_addr)
                watchdog_pkg::OFS_RELOAD_VALUE: nxt_rdata = {16'h0000, reload_value_ff};
                watchdog_pkg::OFS_CONTROL: nxt_rdata = {22'h000000, control_ff};
                watchdog_pkg::OFS_CURRENT_COUNT: begin
                    nxt_rdata = {16'h0000, current_count_ff};
                end
                watchdog_pkg::OFS_EXPIRY_STATUS: nxt_rdata = {31'h0, expiry_pending_ff};
                watchdog_pkg::OFS_INT_ENABLE: nxt_rdata = {31'h0, int_enable_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // Expiry outputs
    always_comb begin
        nxt_event = expire;
        nxt_sub_reset = expire & ~control_ff[watchdog_pkg::CTL_IRQ_SELECT];
        nxt_irq = nxt_expiry_pending & nxt_int_enable;
        nxt_latched = latched_ff | expire;
        nxt_record = record_ff | expire;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            event_ff <= 1'b0;
            sub_reset_ff <= 1'b0;
            irq_ff <= 1'b0;
            latched_ff <= 1'b0;
        end else begin
            event_ff <= nxt_event;
            sub_reset_ff <= nxt_sub_reset;
            irq_ff <= nxt_irq;
            latched_ff <= nxt_latched;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_except_expiry_n) begin
        if (!reset_except_expiry_n) begin
            record_ff <= 1'b0;
        end else begin
            record_ff <= nxt_record;
        end
    end

    assign host_rdata = rdata_ff;
    assign expiry_event = event_ff;
    assign expiry_interrupt = irq_ff;
    assign subsystem_reset = sub_reset_ff;
    assign expiry_latched = latched_ff;
    assign expiry_record = record_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    expiry_irq_a: assert property (
        expire && control_ff[9] && !ctl_wr |=> expiry_pending_ff && !control_ff[9] && expiry_event
    ) else $error("interrupt expiry did not set pending and clear select");

    expiry_reset_a: assert property (
        expire && !control_ff[9] |=> subsystem_reset && expiry_event ##1 !expiry_event
    ) else $error("reset expiry did not pulse subsystem reset once");

    latched_hold_a: assert property (
        expiry_latched |=> expiry_latched
    ) else $error("expiry indication dropped before system reset");

    disabled_hold_a: assert property (
        !control_ff[0] && !load_wr |=> $stable(current_count_ff)
    ) else $error("counter moved while disabled");

    reload_write_a: assert property (
        load_wr |=> current_count_ff == $past(host_wdata[15:0])
            && reload_value_ff == $past(host_wdata[15:0])
    ) else $error("reload write did not load counter");

    kick_reload_a: assert property (
        kick_wr && !load_wr |=> current_count_ff ==
            ($past(control_ff[0]) ? $past(reload_value_ff) : $past(current_count_ff))
    ) else $error("restart strobe misbehaved");

    stall_hold_a: assert property (
        stall_active && !load_wr && !kick_live |=> $stable(current_count_ff) && $stable(prescale_ff)
    ) else $error("counter moved while stalled");

    decrement_a: assert property (
        tick_due && current_count_ff != 16'h0000 && !load_wr && !kick_live
            |=> current_count_ff == $past(current_count_ff) - 16'h0001
    ) else $error("counter did not decrement on 33rd slow edge");

    prescale_range_a: assert property (
        prescale_ff <= 6'h20
    ) else $error("prescaler beyond 33 periods");

    pending_clear_a: assert property (
        status_wr && host_wdata[0] && !expire |=> !expiry_pending_ff
    ) else $error("write-one did not clear pending");

    record_set_a: assert property (
        expire |=> expiry_record && expiry_latched
    ) else $error("expiry not recorded");

    count_read_a: assert property (
        host_rd && host_addr == 8'h0C |=> host_rdata == {16'h0000, $past(current_count_ff)}
    ) else $error("count read mismatch");

endmodule : watchdog_timer

/* File: test/watchdog_timer_bench.sv */
// Self-checking testbench for the watchdog timer
module watchdog_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Signals
    logic ref_clk, reset_n, reset_except_expiry_n, slow_clk_32k;
    logic [3:0] stall_src;
    logic [7:0] host_addr;
    logic host_wr, host_rd;
    logic [31:0] host_wdata, host_rdata;
    logic expiry_event, expiry_interrupt, subsystem_reset, expiry_latched, expiry_record;
    int fails, total_checks, cycles, events_seen, resets_seen;
    int stall_bit [4] = '{4, 3, 2, 2};
    logic [7:0] reg_ofs [7] = '{watchdog_pkg::OFS_RELOAD_VALUE, watchdog_pkg::OFS_CONTROL,
        watchdog_pkg::OFS_RESTART_STROBE, watchdog_pkg::OFS_CURRENT_COUNT,
        watchdog_pkg::OFS_EXPIRY_STATUS, watchdog_pkg::OFS_INT_ENABLE, 8'h18};
    logic [31:0] reg_rst [7] = '{32'h0000FFFF, 32'h0, 32'h0, 32'h0000FFFF, 32'h0, 32'h0, 32'h0};

    watchdog_timer dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .reset_except_expiry_n(reset_except_expiry_n),
        .slow_clk_32k(slow_clk_32k), .debug_active(stall_src[0]),
        .week_timer_active(stall_src[1]), .hib_timer0_active(stall_src[2]),
        .hib_timer1_active(stall_src[3]), .host_addr(host_addr), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .expiry_event(expiry_event), .expiry_interrupt(expiry_interrupt),
        .subsystem_reset(subsystem_reset), .expiry_latched(expiry_latched),
        .expiry_record(expiry_record)
    );

    // ==========================================================
    // Clock, pulse monitor, timeout
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk) begin
        if (expiry_event === 1'b1) events_seen++;
        if (subsystem_reset === 1'b1) resets_seen++;
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
        @(negedge ref_clk);
        host_addr = addr;
        host_wdata = data;
        host_wr = 1'b1;
        @(negedge ref_clk);
        host_wr = 1'b0;
    endtask : reg_write

    task automatic read_check(input string what, input logic [7:0] addr, input logic [31:0] exp);
        @(negedge ref_clk);
        host_addr = addr;
        host_rd = 1'b1;
        @(negedge ref_clk);
        host_rd = 1'b0;
        check(what, host_rdata, exp);
    endtask : read_check

    task automatic slow_edges(input int n);
        repeat (n) begin
            repeat (5) @(negedge ref_clk);
            slow_clk_32k = 1'b1;
            repeat (5) @(negedge ref_clk);
            slow_clk_32k = 1'b0;
        end
        repeat (6) @(negedge ref_clk);
    endtask : slow_edges

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Main sequence
    initial begin
        reset_n = 1'b0;
        reset_except_expiry_n = 1'b0;
        slow_clk_32k = 1'b0;
        stall_src = 4'h0;
        host_addr = 8'h00;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 32'h0;
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        reset_except_expiry_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        // Reset values, strobe and unmapped reads
        for (int i = 0; i < 7; i++) begin
            read_check("reset value", reg_ofs[i], reg_rst[i]);
        end
        // Load then enable; reserved bits read zero
        reg_write(watchdog_pkg::OFS_RELOAD_VALUE, 32'hABCD0005);
        read_check("reload", watchdog_pkg::OFS_RELOAD_VALUE, 32'h5);
        read_check("count after load", watchdog_pkg::OFS_CURRENT_COUNT, 32'h5);
        reg_write(watchdog_pkg::OFS_CONTROL, 32'hFFFFFFFF);
        read_check("control mask", watchdog_pkg::OFS_CONTROL, 32'h0000021D);
        reg_write(watchdog_pkg::OFS_CONTROL, 32'h1);
        slow_edges(32);
        read_check("count at 32 edges", watchdog_pkg::OFS_CURRENT_COUNT, 32'h5);
        slow_edges(1);
        read_check("count at 33 edges", watchdog_pkg::OFS_CURRENT_COUNT, 32'h4);
        // Each stall source, enabled then masked
        for (int i = 0; i < 4; i++) begin
            reg_write(watchdog_pkg::OFS_CONTROL, 32'h1 | (32'h1 << stall_bit[i]));
            stall_src[i] = 1'b1;
            slow_edges(33);
            read_check("stalled", watchdog_pkg::OFS_CURRENT_COUNT, 32'(4 - i));
            reg_write(watchdog_pkg::OFS_CONTROL, 32'h1);
            slow_edges(33);
            read_check("stall masked", watchdog_pkg::OFS_CURRENT_COUNT, 32'(3 - i));
            stall_src[i] = 1'b0;
        end
        // Disabled: frozen, strobe ignored
        reg_write(watchdog_pkg::OFS_CONTROL, 32'h0);
        slow_edges(33);
        read_check("disabled", watchdog_pkg::OFS_CURRENT_COUNT, 32'h0);
        reg_write(watchdog_pkg::OFS_RESTART_STROBE, 32'h000000FF);
        read_check("strobe disabled", watchdog_pkg::OFS_CURRENT_COUNT, 32'h0);
        // Strobe while enabled reloads
        reg_write(watchdog_pkg::OFS_RELOAD_VALUE, 32'h7);
        reg_write(watchdog_pkg::OFS_CONTROL, 32'h1);
        slow_edges(33);
        read_check("count before strobe", watchdog_pkg::OFS_CURRENT_COUNT, 32'h6);
        reg_write(watchdog_pkg::OFS_RESTART_STROBE, 32'h0000005A);
        read_check("strobe enabled", watchdog_pkg::OFS_CURRENT_COUNT, 32'h7);
        // Expiry routed to the interrupt
        reg_write(watchdog_pkg::OFS_INT_ENABLE, 32'h1);
        read_check("int enable", watchdog_pkg::OFS_INT_ENABLE, 32'h1);
        reg_write(watchdog_pkg::OFS_RELOAD_VALUE, 32'h1);
        reg_write(watchdog_pkg::OFS_CONTROL, 32'h201);
        slow_edges(66);
        check("event pulses", 32'(events_seen), 32'h1);
        check("subsystem resets", 32'(resets_seen), 32'h0);
        check("interrupt", 32'(expiry_interrupt), 32'h1);
        check("record", 32'(expiry_record), 32'h1);
        read_check("pending", watchdog_pkg::OFS_EXPIRY_STATUS, 32'h1);
        read_check("select cleared", watchdog_pkg::OFS_CONTROL, 32'h1);
        read_check("reloaded on expiry", watchdog_pkg::OFS_CURRENT_COUNT, 32'h1);
        reg_write(watchdog_pkg::OFS_EXPIRY_STATUS, 32'h1);
        read_check("pending cleared", watchdog_pkg::OFS_EXPIRY_STATUS, 32'h0);
        check("interrupt cleared", 32'(expiry_interrupt), 32'h0);
        check("latched held", 32'(expiry_latched), 32'h1);
        // Expiry routed to the subsystem reset
        slow_edges(66);
        check("event pulses", 32'(events_seen), 32'h2);
        check("subsystem resets", 32'(resets_seen), 32'h1);
        read_check("no pending", watchdog_pkg::OFS_EXPIRY_STATUS, 32'h0);
        // System reset keeps the preserved record
        reset_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        check("latched after reset", 32'(expiry_latched), 32'h0);
        check("record kept", 32'(expiry_record), 32'h1);
        for (int i = 0; i < 6; i++) begin
            read_check("value after reset", reg_ofs[i], reg_rst[i]);
        end
        reset_except_expiry_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        reset_except_expiry_n = 1'b1;
        @(negedge ref_clk);
        check("record cleared", 32'(expiry_record), 32'h0);
        tally_and_finish();
    end

endmodule : watchdog_timer_bench
